// >>> pkg/mti_regs.svh
/*
  Constants of the instruction timing core: opcodes, direct-space
  addresses, status bit positions, lengths and cycle counts.
  Assumes it is included once per compilation unit by bare name.
*/
`ifndef MTI_REGS_SVH
`define MTI_REGS_SVH

// Memory sizes
`define MTI_CODE_AW      13
`define MTI_RAM_DEPTH    256

// Direct-space special registers and the bit-area base
`define MTI_SFR_SP       8'h81
`define MTI_SFR_DPL      8'h82
`define MTI_SFR_DPH      8'h83
`define MTI_SFR_PSW      8'hd0
`define MTI_SFR_ACC      8'he0
`define MTI_SFR_B        8'hf0
`define MTI_BIT_BASE     8'h20

// Reset values
`define MTI_SP_RST       8'h07
`define MTI_PC_RST       16'h0000

// Status word bit positions
`define MTI_PSW_CY       7
`define MTI_PSW_AC       6
`define MTI_PSW_RS1      4
`define MTI_PSW_RS0      3
`define MTI_PSW_OV       2
`define MTI_PSW_P        0

// Opcode groups: high nibble, low nibble operand modes
`define MTI_HI_ADD       4'h2
`define MTI_HI_ADDC      4'h3
`define MTI_HI_ANL       4'h5
`define MTI_HI_SUBB      4'h9
`define MTI_HI_XCH       4'hc
`define MTI_LO_IMM       4'h4
`define MTI_LO_DIR       4'h5
`define MTI_LO_IND0      4'h6
`define MTI_LO_IND1      4'h7
`define MTI_MOVX_RI_BIT  1

// Single opcodes
`define MTI_OP_NOP       8'h00
`define MTI_OP_JBC       8'h10
`define MTI_OP_JB        8'h20
`define MTI_OP_JNB       8'h30
`define MTI_OP_JC        8'h40
`define MTI_OP_JNC       8'h50
`define MTI_OP_JZ        8'h60
`define MTI_OP_JNZ       8'h70
`define MTI_OP_JMPA      8'h73
`define MTI_OP_SJMP      8'h80
`define MTI_OP_ANLC_BIT  8'h82
`define MTI_OP_MOVC_PC   8'h83
`define MTI_OP_ANLC_NBIT 8'hb0
`define MTI_OP_PUSH      8'hc0
`define MTI_OP_POP       8'hd0
`define MTI_OP_XCHD0     8'hd6
`define MTI_OP_XCHD1     8'hd7
`define MTI_OP_MOVX_RDD  8'he0
`define MTI_OP_MOVX_RDR0 8'he2
`define MTI_OP_MOVX_RDR1 8'he3
`define MTI_OP_MOVX_WRD  8'hf0
`define MTI_OP_MOVX_WRR0 8'hf2
`define MTI_OP_MOVX_WRR1 8'hf3

// Instruction lengths in bytes and durations in clocks
`define MTI_LEN_1        2'd1
`define MTI_LEN_2        2'd2
`define MTI_LEN_3        2'd3
`define MTI_CYC_1        3'd1
`define MTI_CYC_2        3'd2
`define MTI_CYC_3        3'd3
`define MTI_CYC_4        3'd4

`endif

// >>> pkg/mti_pkg.sv
/*
  Types of the instruction timing core: instruction classes, operand
  modes and sequencer states.
  Assumes nothing of its surroundings.
*/
package mti_pkg;

  typedef enum logic [4:0] {
    MTI_C_BAD   = 5'b00000,
    MTI_C_NOP   = 5'b00001,
    MTI_C_ARITH = 5'b00010,
    MTI_C_ANL   = 5'b00011,
    MTI_C_XCH   = 5'b00100,
    MTI_C_XCHD  = 5'b00101,
    MTI_C_MOVXR = 5'b00110,
    MTI_C_MOVXW = 5'b00111,
    MTI_C_MOVC  = 5'b01000,
    MTI_C_PUSH  = 5'b01001,
    MTI_C_POP   = 5'b01010,
    MTI_C_ANLC  = 5'b01011,
    MTI_C_JC    = 5'b01100,
    MTI_C_JNC   = 5'b01101,
    MTI_C_JZ    = 5'b01110,
    MTI_C_JNZ   = 5'b01111,
    MTI_C_JB    = 5'b10000,
    MTI_C_JNB   = 5'b10001,
    MTI_C_JBC   = 5'b10010,
    MTI_C_JMPA  = 5'b10011,
    MTI_C_SJMP  = 5'b10100
  } mti_class_e;

  typedef enum logic [1:0] {
    MTI_SRC_IMM = 2'b00,
    MTI_SRC_DIR = 2'b01,
    MTI_SRC_IND = 2'b10,
    MTI_SRC_REG = 2'b11
  } mti_src_e;

  typedef enum logic [0:0] {
    MTI_ST_RUN  = 1'b0,
    MTI_ST_HOLD = 1'b1
  } mti_state_e;

endpackage : mti_pkg

// >>> src/mti_alu.sv
/*
  Eight-bit adder and subtractor with carry or borrow in, giving
  carry, auxiliary carry and overflow.
  Assumes a combinational path; the caller registers the results.
*/
`timescale 1ns/1ns
`default_nettype none

module mti_alu (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  output logic      [7:0] res,
  output logic            cy,
  output logic            ac,
  output logic            ov
);

  logic [8:0] full;
  logic [4:0] half;

  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
    res = full[7:0];
    cy  = full[8];
    ac  = half[4];
    if (sub) begin
      ov = (a[7] != b[7]) && (res[7] != a[7]);
    end else begin
      ov = (a[7] == b[7]) && (res[7] != a[7]);
    end
  end

endmodule : mti_alu

`default_nettype wire

// >>> src/mti_decode.sv
/*
  Opcode decoder: instruction class, operand mode, length in bytes,
  and clocks for the not-taken and taken outcome.
  Assumes the opcode byte is stable for the whole instruction.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mti_regs.svh"

module mti_decode
  import mti_pkg::*;
(
  input  wire logic [7:0] opcode,
  output var  mti_class_e cls,
  output var  mti_src_e   src,
  output logic      [1:0] len,
  output logic      [2:0] cyc,
  output logic      [2:0] cyc_tk
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic       grp;

  function automatic mti_src_e src_of(input logic [3:0] l);
    mti_src_e s;
    s = MTI_SRC_REG;
    if (l == `MTI_LO_IMM) s = MTI_SRC_IMM;
    else if (l == `MTI_LO_DIR) s = MTI_SRC_DIR;
    else if (l == `MTI_LO_IND0 || l == `MTI_LO_IND1) s = MTI_SRC_IND;
    return s;
  endfunction : src_of

  assign hi  = opcode[7:4];
  assign lo  = opcode[3:0];
  assign grp = (lo >= `MTI_LO_IMM) &&
               (hi == `MTI_HI_ADD || hi == `MTI_HI_ADDC ||
                hi == `MTI_HI_SUBB || hi == `MTI_HI_ANL ||
                (hi == `MTI_HI_XCH && lo != `MTI_LO_IMM));

  always_comb begin
    cls    = MTI_C_BAD;
    src    = MTI_SRC_IND;
    len    = `MTI_LEN_1;
    cyc    = `MTI_CYC_1;
    cyc_tk = `MTI_CYC_1;
    if (grp) begin
      src = src_of(lo);
      if (hi == `MTI_HI_ANL) cls = MTI_C_ANL;
      else if (hi == `MTI_HI_XCH) cls = MTI_C_XCH;
      else cls = MTI_C_ARITH;
      unique case (src)
        MTI_SRC_IMM, MTI_SRC_DIR: begin
          len = `MTI_LEN_2;
          cyc = `MTI_CYC_2;
        end
        MTI_SRC_IND: begin
          len = `MTI_LEN_1;
          cyc = `MTI_CYC_2;
        end
        MTI_SRC_REG: begin
          len = `MTI_LEN_1;
          cyc = `MTI_CYC_1;
        end
      endcase
      cyc_tk = cyc;
    end else begin
      unique case (opcode)
        `MTI_OP_NOP: cls = MTI_C_NOP;
        `MTI_OP_JC, `MTI_OP_JNC, `MTI_OP_JZ, `MTI_OP_JNZ: begin
          if (opcode == `MTI_OP_JC) cls = MTI_C_JC;
          else if (opcode == `MTI_OP_JNC) cls = MTI_C_JNC;
          else if (opcode == `MTI_OP_JZ) cls = MTI_C_JZ;
          else cls = MTI_C_JNZ;
          len    = `MTI_LEN_2;
          cyc    = `MTI_CYC_2;
          cyc_tk = `MTI_CYC_3;
        end
        `MTI_OP_JB, `MTI_OP_JNB, `MTI_OP_JBC: begin
          if (opcode == `MTI_OP_JB) cls = MTI_C_JB;
          else if (opcode == `MTI_OP_JNB) cls = MTI_C_JNB;
          else cls = MTI_C_JBC;
          len    = `MTI_LEN_3;
          cyc    = `MTI_CYC_3;
          cyc_tk = `MTI_CYC_4;
        end
        `MTI_OP_SJMP: begin
          cls    = MTI_C_SJMP;
          len    = `MTI_LEN_2;
          cyc    = `MTI_CYC_3;
          cyc_tk = `MTI_CYC_3;
        end
        `MTI_OP_JMPA: begin
          cls    = MTI_C_JMPA;
          cyc    = `MTI_CYC_3;
          cyc_tk = `MTI_CYC_3;
        end
        `MTI_OP_MOVC_PC: begin
          cls    = MTI_C_MOVC;
          cyc    = `MTI_CYC_3;
          cyc_tk = `MTI_CYC_3;
        end
        `MTI_OP_MOVX_RDD, `MTI_OP_MOVX_RDR0, `MTI_OP_MOVX_RDR1: begin
          cls    = MTI_C_MOVXR;
          cyc    = `MTI_CYC_3;
          cyc_tk = `MTI_CYC_3;
        end
        `MTI_OP_MOVX_WRD, `MTI_OP_MOVX_WRR0, `MTI_OP_MOVX_WRR1: begin
          cls    = MTI_C_MOVXW;
          cyc    = `MTI_CYC_3;
          cyc_tk = `MTI_CYC_3;
        end
        `MTI_OP_PUSH, `MTI_OP_POP: begin
          cls    = (opcode == `MTI_OP_PUSH) ? MTI_C_PUSH : MTI_C_POP;
          len    = `MTI_LEN_2;
          cyc    = `MTI_CYC_2;
          cyc_tk = `MTI_CYC_2;
        end
        `MTI_OP_XCHD0, `MTI_OP_XCHD1: begin
          cls    = MTI_C_XCHD;
          cyc    = `MTI_CYC_2;
          cyc_tk = `MTI_CYC_2;
        end
        `MTI_OP_ANLC_BIT, `MTI_OP_ANLC_NBIT: begin
          cls    = MTI_C_ANLC;
          len    = `MTI_LEN_2;
          cyc    = `MTI_CYC_2;
          cyc_tk = `MTI_CYC_2;
        end
        default: cls = MTI_C_BAD;
      endcase
    end
  end

endmodule : mti_decode

`default_nettype wire

// >>> src/mti_core.sv
/*
  Instruction sequencer of an 8-bit core: executes a subset of the
  classic instruction set with exact byte lengths and clock counts,
  program memory and data RAM both on chip.
  Assumes core_hold and the load port come from logic on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mti_regs.svh"

module mti_core
  import mti_pkg::*;
#(
  parameter int CODE_AW = `MTI_CODE_AW
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               core_hold,
  input  wire logic               prog_we,
  input  wire logic [CODE_AW-1:0] prog_addr,
  input  wire logic         [7:0] prog_wdata,
  output logic             [15:0] prog_counter,
  output logic              [7:0] accum,
  output logic              [7:0] psw_flags,
  output logic              [7:0] stack_ptr,
  output logic             [15:0] data_ptr,
  output logic                    retire,
  output logic                    unsupported,
  output logic                    halted
);

  localparam int CODE_DEPTH = 1 << CODE_AW;

  // On-chip program memory and data RAM
  logic [7:0] flash_q [CODE_DEPTH];
  logic [7:0] ram_q   [`MTI_RAM_DEPTH];

  mti_state_e  st_q, st_d;
  logic [15:0] pc_q, pc_d, dptr_q, dptr_d;
  logic  [7:0] acc_q, acc_d, b_q, b_d, psw_q, psw_d, sp_q, sp_d;
  logic  [2:0] cyc_q, cyc_d;
  logic        ret_q, ret_d, uns_q, uns_d;

  mti_class_e  cls;
  mti_src_e    src;
  logic  [1:0] len;
  logic  [2:0] cyc, cyc_tk, need;
  logic  [7:0] opc, op1, op2, opnd, ri_v, bit_byte, bit_home_a, rel;
  logic  [7:0] reg_a, ri_a, alu_res;
  logic [15:0] p1, p2, pc_nxt, movx_a, movc_a;
  logic        alu_cy, alu_ac, alu_ov, alu_sub, alu_cin;
  logic        bit_v, taken, go, last;
  logic        wr_we, wr_ind, fl_we;
  logic  [7:0] wr_a, wr_d, fl_wd;
  logic [15:0] fl_wa;

  // Direct-space read: low half is RAM, high half special registers
  function automatic logic [7:0] rd_dir(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) begin
      v = ram_q[a];
    end else begin
      case (a)
        `MTI_SFR_ACC: v = acc_q;
        `MTI_SFR_B:   v = b_q;
        `MTI_SFR_PSW: v = psw_q;
        `MTI_SFR_SP:  v = sp_q;
        `MTI_SFR_DPL: v = dptr_q[7:0];
        `MTI_SFR_DPH: v = dptr_q[15:8];
        default:      v = 8'h00;
      endcase
    end
    return v;
  endfunction : rd_dir

  function automatic logic [7:0] code_rd(input logic [15:0] a);
    return flash_q[a[CODE_AW-1:0]];
  endfunction : code_rd

  function automatic logic [15:0] rel_add(input logic [15:0] base,
                                          input logic  [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction : rel_add

  mti_decode u_dec (
    .opcode (opc),
    .cls    (cls),
    .src    (src),
    .len    (len),
    .cyc    (cyc),
    .cyc_tk (cyc_tk)
  );

  mti_alu u_alu (
    .a   (acc_q),
    .b   (opnd),
    .cin (alu_cin),
    .sub (alu_sub),
    .res (alu_res),
    .cy  (alu_cy),
    .ac  (alu_ac),
    .ov  (alu_ov)
  );

  // Operand fetch and branch decision
  always_comb begin
    p1         = pc_q + 16'h0001;
    p2         = pc_q + 16'h0002;
    opc        = code_rd(pc_q);
    op1        = code_rd(p1);
    op2        = code_rd(p2);
    pc_nxt     = pc_q + {14'h0000, len};
    reg_a      = {3'b000, psw_q[`MTI_PSW_RS1:`MTI_PSW_RS0], opc[2:0]};
    ri_a       = {3'b000, psw_q[`MTI_PSW_RS1:`MTI_PSW_RS0], 2'b00, opc[0]};
    ri_v       = ram_q[ri_a];
    unique case (src)
      MTI_SRC_IMM: opnd = op1;
      MTI_SRC_DIR: opnd = rd_dir(op1);
      MTI_SRC_IND: opnd = ram_q[ri_v];
      MTI_SRC_REG: opnd = ram_q[reg_a];
    endcase
    alu_sub    = (opc[7:4] == `MTI_HI_SUBB);
    alu_cin    = (opc[7:4] != `MTI_HI_ADD) && psw_q[`MTI_PSW_CY];
    bit_home_a = op1[7] ? {op1[7:3], 3'b000}
                        : `MTI_BIT_BASE + {4'h0, op1[6:3]};
    bit_byte   = rd_dir(bit_home_a);
    bit_v      = bit_byte[op1[2:0]];
    rel        = (cls == MTI_C_JB || cls == MTI_C_JNB || cls == MTI_C_JBC)
                 ? op2 : op1;
    movx_a     = opc[`MTI_MOVX_RI_BIT] ? {dptr_q[15:8], ri_v} : dptr_q;
    movc_a     = pc_nxt + {8'h00, acc_q};
    unique case (cls)
      MTI_C_JC:  taken = psw_q[`MTI_PSW_CY];
      MTI_C_JNC: taken = !psw_q[`MTI_PSW_CY];
      MTI_C_JZ:  taken = (acc_q == 8'h00);
      MTI_C_JNZ: taken = (acc_q != 8'h00);
      MTI_C_JB, MTI_C_JBC: taken = bit_v;
      MTI_C_JNB: taken = !bit_v;
      default:   taken = 1'b0;
    endcase
    need = taken ? cyc_tk : cyc;
    go   = (st_q == MTI_ST_RUN) && !(cyc_q == 3'd0 && core_hold);
    last = go && (cyc_q == need - 3'd1);
  end

  // Sequencer and architectural state
  always_comb begin
    st_d   = st_q;
    pc_d   = pc_q;
    acc_d  = acc_q;
    b_d    = b_q;
    psw_d  = psw_q;
    sp_d   = sp_q;
    dptr_d = dptr_q;
    cyc_d  = cyc_q;
    ret_d  = 1'b0;
    uns_d  = 1'b0;
    wr_we  = 1'b0;
    wr_ind = 1'b0;
    wr_a   = 8'h00;
    wr_d   = 8'h00;
    fl_we  = 1'b0;
    fl_wa  = 16'h0000;
    fl_wd  = 8'h00;
    unique case (st_q)
      MTI_ST_HOLD: begin
        if (!core_hold) st_d = MTI_ST_RUN;
        fl_we = prog_we;
        fl_wa = 16'({prog_addr});
        fl_wd = prog_wdata;
      end
      MTI_ST_RUN: begin
        if (cyc_q == 3'd0 && core_hold) st_d = MTI_ST_HOLD;
        if (go) cyc_d = cyc_q + 3'd1;
        if (last) begin
          cyc_d = 3'd0;
          ret_d = 1'b1;
          pc_d  = pc_nxt;
          unique case (cls)
            MTI_C_ARITH: begin
              acc_d              = alu_res;
              psw_d[`MTI_PSW_CY] = alu_cy;
              psw_d[`MTI_PSW_AC] = alu_ac;
              psw_d[`MTI_PSW_OV] = alu_ov;
            end
            MTI_C_ANL: acc_d = acc_q & opnd;
            MTI_C_XCH: begin
              acc_d  = opnd;
              wr_we  = 1'b1;
              wr_ind = (src != MTI_SRC_DIR);
              wr_a   = (src == MTI_SRC_DIR) ? op1 :
                       (src == MTI_SRC_IND) ? ri_v : reg_a;
              wr_d   = acc_q;
            end
            MTI_C_XCHD: begin
              acc_d  = {acc_q[7:4], opnd[3:0]};
              wr_we  = 1'b1;
              wr_ind = 1'b1;
              wr_a   = ri_v;
              wr_d   = {opnd[7:4], acc_q[3:0]};
            end
            MTI_C_MOVXR: acc_d = code_rd(movx_a);
            MTI_C_MOVXW: begin
              fl_we = 1'b1;
              fl_wa = movx_a;
              fl_wd = acc_q;
            end
            MTI_C_MOVC: acc_d = code_rd(movc_a);
            MTI_C_PUSH: begin
              sp_d   = sp_q + 8'h01;
              wr_we  = 1'b1;
              wr_ind = 1'b1;
              wr_a   = sp_q + 8'h01;
              wr_d   = rd_dir(op1);
            end
            MTI_C_POP: begin
              sp_d  = sp_q - 8'h01;
              wr_we = 1'b1;
              wr_a  = op1;
              wr_d  = ram_q[sp_q];
            end
            MTI_C_ANLC: begin
              psw_d[`MTI_PSW_CY] = psw_q[`MTI_PSW_CY] &
                ((opc == `MTI_OP_ANLC_NBIT) ? !bit_v : bit_v);
            end
            MTI_C_JC, MTI_C_JNC, MTI_C_JZ, MTI_C_JNZ,
            MTI_C_JB, MTI_C_JNB: begin
              if (taken) pc_d = rel_add(pc_nxt, rel);
            end
            MTI_C_JBC: begin
              if (taken) begin
                pc_d  = rel_add(pc_nxt, rel);
                wr_we = 1'b1;
                wr_a  = bit_home_a;
                wr_d  = bit_byte & ~(8'h01 << op1[2:0]);
              end
            end
            MTI_C_JMPA: pc_d = dptr_q + {8'h00, acc_q};
            MTI_C_SJMP: pc_d = rel_add(pc_nxt, op1);
            MTI_C_NOP: ;
            default: uns_d = 1'b1;
          endcase
          // Direct writes into the special registers win last
          if (wr_we && !wr_ind && wr_a[7]) begin
            case (wr_a)
              `MTI_SFR_ACC: acc_d = wr_d;
              `MTI_SFR_B:   b_d = wr_d;
              `MTI_SFR_PSW: psw_d = wr_d;
              `MTI_SFR_SP:  sp_d = wr_d;
              `MTI_SFR_DPL: dptr_d[7:0] = wr_d;
              `MTI_SFR_DPH: dptr_d[15:8] = wr_d;
              default: ;
            endcase
          end
          psw_d[`MTI_PSW_P] = ^acc_d;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q   <= MTI_ST_RUN;
      pc_q   <= `MTI_PC_RST;
      acc_q  <= 8'h00;
      b_q    <= 8'h00;
      psw_q  <= 8'h00;
      sp_q   <= `MTI_SP_RST;
      dptr_q <= 16'h0000;
      cyc_q  <= 3'd0;
      ret_q  <= 1'b0;
      uns_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      pc_q   <= pc_d;
      acc_q  <= acc_d;
      b_q    <= b_d;
      psw_q  <= psw_d;
      sp_q   <= sp_d;
      dptr_q <= dptr_d;
      cyc_q  <= cyc_d;
      ret_q  <= ret_d;
      uns_q  <= uns_d;
    end
  end

  // Memory writes; contents are not reset
  always_ff @(posedge ref_clk) begin
    if (rst_n && wr_we && (wr_ind || !wr_a[7])) ram_q[wr_a] <= wr_d;
    if (rst_n && fl_we) flash_q[fl_wa[CODE_AW-1:0]] <= fl_wd;
  end

  assign prog_counter = pc_q;
  assign accum        = acc_q;
  assign psw_flags    = psw_q;
  assign stack_ptr    = sp_q;
  assign data_ptr     = dptr_q;
  assign retire       = ret_q;
  assign unsupported  = uns_q;
  assign halted       = (st_q == MTI_ST_HOLD);

endmodule : mti_core

`default_nettype wire

// >>> verification/mti_core_chk.sv
/* Port checker for mti_core: timing and hold behaviour.
   Assumes the bind below attaches it to every mti_core. */
`timescale 1ns/1ns
`default_nettype none
module mti_core_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        core_hold,
  input wire logic [15:0] prog_counter,
  input wire logic  [7:0] accum,
  input wire logic  [7:0] stack_ptr,
  input wire logic        retire,
  input wire logic        unsupported,
  input wire logic        halted
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst_state;
    $rose(rst_n) |-> prog_counter == 16'h0000 && accum == 8'h00
      && stack_ptr == 8'h07 && !halted;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("state wrong after reset");
  property p_unsup;
    unsupported |-> retire;
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("unsupported without retire");
  property p_pc_move;
    $changed(prog_counter) |-> retire;
  endproperty
  a_pc_move: assert property (p_pc_move)
    else $error("pc moved between retires");
  property p_acc_move;
    $changed(accum) |-> retire;
  endproperty
  a_acc_move: assert property (p_acc_move)
    else $error("accumulator moved between retires");
  property p_sp_move;
    $changed(stack_ptr) |-> retire;
  endproperty
  a_sp_move: assert property (p_sp_move)
    else $error("stack pointer moved between retires");
  property p_gap;
    retire && !core_hold ##1 (!retire && !core_hold)[*3] |=> retire;
  endproperty
  a_gap: assert property (p_gap)
    else $error("instruction longer than four clocks");
  property p_hold_in;
    (core_hold && !halted)[*5] |=> halted;
  endproperty
  a_hold_in: assert property (p_hold_in)
    else $error("hold not taken at boundary");
  property p_freeze;
    halted && $past(halted) |-> !retire && $stable(prog_counter);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("core ran while halted");
  property p_hold_out;
    halted && !core_hold |=> !halted;
  endproperty
  a_hold_out: assert property (p_hold_out)
    else $error("hold not left");
  c_three: cover property (retire ##3 retire);
  c_halt: cover property ($rose(halted));
  c_resume: cover property ($fell(halted));
endmodule : mti_core_chk
bind mti_core mti_core_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .core_hold(core_hold),
  .prog_counter(prog_counter), .accum(accum), .stack_ptr(stack_ptr),
  .retire(retire), .unsupported(unsupported), .halted(halted)
);
`default_nettype wire

// >>> verification/mcu8051_instr_timing_tb_top.sv
/* Bench for mti_core: loads a program, checks clocks and results.
   Assumes mti_core_chk is bound to the core. */
`timescale 1ns/1ns
`default_nettype none
module mcu8051_instr_timing_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        core_hold = 1'b1;
  logic        prog_we = 1'b0;
  logic  [7:0] prog_addr = 8'h00;
  logic  [7:0] prog_wdata = 8'h00;
  logic [15:0] prog_counter;
  logic  [7:0] accum;
  logic  [7:0] psw_flags;
  logic  [7:0] stack_ptr;
  logic [15:0] data_ptr;
  logic        retire;
  logic        unsupported;
  logic        halted;
  int          bad_count = 0;
  int          num_checks = 0;
  logic  [7:0] img [0:25] = '{8'h34, 8'hff, 8'h34, 8'h01, 8'h94, 8'h00,
    8'h40, 8'h02, 8'h00, 8'h00, 8'h50, 8'h05, 8'h60, 8'h05, 8'hc0, 8'he0,
    8'hd0, 8'hf0, 8'he0, 8'h83, 8'h60, 8'h02, 8'h00, 8'h00, 8'h80, 8'hfe};
  logic  [7:0] img2 [0:25] = '{8'h24, 8'h08, 8'hc0, 8'he0, 8'hd0, 8'h00,
    8'h24, 8'hf5, 8'hd6, 8'h56, 8'h96, 8'h38, 8'hc5, 8'h08, 8'hf2, 8'h10,
    8'he2, 8'h01, 8'ha4, 8'he2, 8'hb0, 8'he0, 8'ha4, 8'h73, 8'h00, 8'h00};
  always #5 ref_clk = ~ref_clk;
  mti_core #(.CODE_AW(8)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .core_hold(core_hold),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_counter(prog_counter), .accum(accum), .psw_flags(psw_flags),
    .stack_ptr(stack_ptr), .data_ptr(data_ptr), .retire(retire),
    .unsupported(unsupported), .halted(halted)
  );
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic reset_core();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    core_hold <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("pc", 16'h0000, prog_counter);
    chk("sp", 16'h0007, {8'h00, stack_ptr});
    chk("dptr", 16'h0000, data_ptr);
    @(posedge ref_clk);
    #1;
    chk("halted", 16'h0001, {15'h0, halted});
  endtask : reset_core
  task automatic load_program(input bit sel);
    for (int i = 0; i < 27; i++) begin
      @(posedge ref_clk);
      prog_we <= 1'b1;
      prog_addr <= (i < 26) ? 8'(i) : 8'h48;
      prog_wdata <= (i == 26) ? 8'h00 : (sel ? img2[i] : img[i]);
    end
    @(posedge ref_clk);
    prog_we <= 1'b0;
  endtask : load_program
  // Wait one retire; cyc 0 skips the clock count
  task automatic step(input logic [15:0] pc, input int cyc,
                      input logic [7:0] acc, input logic cy);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (retire !== 1'b1 && n < 10);
    if (cyc > 0) chk("clocks", 16'(cyc), 16'(n));
    chk("pc", pc, prog_counter);
    chk("acc", {8'h00, acc}, {8'h00, accum});
    chk("cy", {15'h0, cy}, {15'h0, psw_flags[7]});
  endtask : step
  task automatic run_program();
    @(posedge ref_clk);
    core_hold <= 1'b0;
    step(16'h0002, 0, 8'hff, 1'b0);
    step(16'h0004, 2, 8'h00, 1'b1);
    step(16'h0006, 2, 8'hff, 1'b1);
    step(16'h000a, 3, 8'hff, 1'b1);
    step(16'h000c, 2, 8'hff, 1'b1);
    step(16'h000e, 2, 8'hff, 1'b1);
    step(16'h0010, 2, 8'hff, 1'b1);
    chk("sp", 16'h0008, {8'h00, stack_ptr});
    step(16'h0012, 2, 8'hff, 1'b1);
    chk("sp", 16'h0007, {8'h00, stack_ptr});
    step(16'h0013, 3, 8'h34, 1'b1);
    step(16'h0014, 3, 8'h00, 1'b1);
    step(16'h0018, 3, 8'h00, 1'b1);
    step(16'h0018, 3, 8'h00, 1'b1);
  endtask : run_program
  // Indirect, nibble, flash write, bit and indirect jump forms
  task automatic run_second();
    @(posedge ref_clk);
    core_hold <= 1'b0;
    step(16'h0002, 0, 8'h08, 1'b0);
    step(16'h0004, 2, 8'h08, 1'b0);
    step(16'h0006, 2, 8'h08, 1'b0);
    step(16'h0008, 2, 8'hfd, 1'b0);
    step(16'h0009, 2, 8'hf8, 1'b0);
    step(16'h000a, 2, 8'h08, 1'b0);
    step(16'h000b, 2, 8'hfb, 1'b1);
    step(16'h000c, 1, 8'h04, 1'b1);
    step(16'h000e, 2, 8'h0d, 1'b1);
    step(16'h000f, 3, 8'h0d, 1'b1);
    step(16'h0013, 4, 8'h09, 1'b1);
    step(16'h0014, 3, 8'h0d, 1'b1);
    step(16'h0016, 2, 8'h0d, 1'b0);
    step(16'h0017, 1, 8'h0d, 1'b0);
    chk("unsup", 16'h0001, {15'h0, unsupported});
    step(16'h000d, 3, 8'h0d, 1'b0);
    chk("unsup", 16'h0000, {15'h0, unsupported});
  endtask : run_second
  // Load port is refused while running, then hold and resume
  task automatic hold_test();
    int n;
    @(posedge ref_clk);
    prog_we <= 1'b1;
    prog_addr <= 8'h18;
    @(posedge ref_clk);
    prog_we <= 1'b0;
    step(16'h0018, 0, 8'h00, 1'b1);
    step(16'h0018, 3, 8'h00, 1'b1);
    @(posedge ref_clk);
    core_hold <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (halted !== 1'b1 && n < 8);
    chk("halted", 16'h0001, {15'h0, halted});
    repeat (4) @(posedge ref_clk);
    #1;
    chk("pc", 16'h0018, prog_counter);
    @(posedge ref_clk);
    core_hold <= 1'b0;
    step(16'h0018, 0, 8'h00, 1'b1);
  endtask : hold_test
  initial begin
    reset_core();
    load_program(1'b0);
    run_program();
    hold_test();
    reset_core();
    load_program(1'b1);
    run_second();
    give_verdict();
  end
  initial begin
    repeat (1000) @(posedge ref_clk);
    bad_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule : mcu8051_instr_timing_tb_top
`default_nettype wire
